// ==== core/fatu_top.sv ====
// Fetch address trap unit: traps fetches from special or RAM areas.
// Notes on behaviour
// RQ1: A trap raises an interrupt or a reset request, per the select bit.
// RQ2: With select 0, special or armed RAM fetches raise the interrupt.
// RQ3: The trap interrupt is non-maskable, ignoring the master flag.
// RQ4: A new trap interrupt is taken at once even during another one.
// RQ5: Software must not nest trap interrupts without the return.
// RQ6: Software sets the stack pointer before choosing interrupt traps.
// RQ7: With select 1, the same offending fetches raise a reset request.
// RQ8: A trap reset resets all internal hardware of the controller.
// RQ9: The trap reset lasts no more than 24 high-frequency clock periods.
// RQ10: In low-speed mode one a trap reset restarts the fast oscillator.
// RQ11: A new RAM trap enable value applies only after the assign code.
// RQ12: Software clears the RAM trap enable before running code from RAM.
// RQ13: A special-area fetch traps whatever the RAM trap enable says.
// RQ14: Each offending fetch is range-checked and traps for one cycle.

`timescale 1ns/1ns
`default_nettype none
module fatu_top
  import fatu_pkg::*;
(
  // Clock and chip reset.
  input wire logic mclk,
  input wire logic resetn,
  // Fetch from the CPU core.
  input wire fatu_fetch_t fetch,
  // Trap configuration from the control bits.
  input wire logic trap_action_select,
  input wire logic ram_trap_enable,
  input wire logic assign_code_write,
  input wire logic low_speed_mode_one,
  // Requests to the CPU core and to the reset and clock logic.
  output logic trap_interrupt_request,
  output logic trap_reset_request,
  output logic internal_resetn,
  output logic high_freq_osc_restart
);
  // Reset release synchroniser.
  logic rst_s1;
  logic rst_s2;

  // Range compare results and the qualified trap conditions.
  fatu_hit_t hit;
  logic trap;
  logic int_trap;
  logic rst_trap;

  // RAM trap arming group.
  logic ram_arm;
  logic next_ram_arm;

  // Trap reset sequencer group.
  fatu_state_t state;
  fatu_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic rst_done;

  // Request output group.
  logic next_int;
  logic next_rreq;
  logic next_irstn;
  logic next_osc;

  // All state leaves reset on the same edge. Only the second stage reads
  // the first, so a late release cannot reach the logic.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // The range compare is purely combinational on the fetch carrier.
  fatu_detect u_detect (
    .fetch(fetch),
    .hit(hit)
  );

  // Special area traps unconditionally; RAM only when armed.
  assign trap = hit.in_sfr || (hit.in_ram && ram_arm); // RQ13

  // Fetches that arrive while the trap reset runs are ignored.
  always_comb
  begin
    int_trap = 1'b0;
    rst_trap = 1'b0;
    if (trap && (state == FATU_RUN))
    begin
      int_trap = !trap_action_select; // RQ1 RQ2
      rst_trap = trap_action_select; // RQ1 RQ7
    end
  end

  // The last count ends the reset; the next fetch is judged afresh.
  assign rst_done = (state == FATU_RESET) && (cnt == RST_LAST); // RQ9

  // The armed copy follows the enable only on the assign code, and goes
  // back to its reset value while the trap reset holds the controller.
  // Software that runs code from RAM must disarm first, since an armed
  // RAM fetch is taken for a runaway program.
  always_comb
  begin
    next_ram_arm = ram_arm;
    if (assign_code_write)
    begin
      next_ram_arm = ram_trap_enable; // RQ11
    end
    if (!internal_resetn)
    begin
      next_ram_arm = 1'b1; // RQ8
    end
  end

  always_ff @(posedge mclk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      ram_arm <= 1'b1;
    end
    else
    begin
      ram_arm <= next_ram_arm;
    end
  end

  // The counter runs from zero up to its last value while the trap reset
  // holds, which keeps the reset inside its longest allowed time.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      FATU_RUN:
      begin
        if (rst_trap)
        begin
          next_cnt = CNT_ZERO;
          next_state = FATU_RESET; // RQ7
        end
      end
      FATU_RESET:
      begin
        // A fetch in this state is not looked at.
        if (rst_done)
        begin
          next_state = FATU_RUN; // RQ9
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      state <= FATU_RUN;
      cnt <= CNT_ZERO;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Requests are pulsed whatever mask or service state the CPU is in,
  // so a second trap during a handler is answered at once.
  always_comb
  begin
    next_int = int_trap; // RQ2 RQ3 RQ4 RQ14
    next_rreq = rst_trap; // RQ7 RQ14
    next_irstn = 1'b1;
    next_osc = 1'b0;
    if (rst_trap)
    begin
      next_irstn = 1'b0; // RQ8
      next_osc = low_speed_mode_one; // RQ10
    end
    if ((state == FATU_RESET) && !rst_done)
    begin
      next_irstn = 1'b0; // RQ8
      // The restart stays up only while the slow mode lasts.
      next_osc = low_speed_mode_one && high_freq_osc_restart; // RQ10
    end
  end

  // Every request leaves through a flip-flop, so the far side sees clean
  // pulses and levels.
  always_ff @(posedge mclk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      trap_interrupt_request <= 1'b0;
      trap_reset_request <= 1'b0;
      internal_resetn <= 1'b1;
      high_freq_osc_restart <= 1'b0;
    end
    else
    begin
      trap_interrupt_request <= next_int;
      trap_reset_request <= next_rreq;
      internal_resetn <= next_irstn; // RQ9
      high_freq_osc_restart <= next_osc;
    end
  end
endmodule
`default_nettype wire

// ==== core/fatu_pkg.sv ====
// Package for the fetch address trap unit: ranges, timings and carriers.
package fatu_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h013f;
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h003f;
  localparam int CLK_HZ = 20000000;
  localparam int HF_CLK_HZ = 16000000;
  localparam int RST_HF_PERIODS = 24;
  // Longest reset: 24 high-frequency periods, rounded down, at least one.
  localparam int RST_CYC_RAW = (RST_HF_PERIODS * (CLK_HZ / 1000)) /
    (HF_CLK_HZ / 1000);
  localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } fatu_fetch_t;

  typedef struct packed {
    logic in_sfr;
    logic in_ram;
  } fatu_hit_t;

  typedef enum logic [0:0] {FATU_RUN, FATU_RESET} fatu_state_t;
endpackage

// ==== core/fatu_detect.sv ====
// Range compare of one fetch address against the special and RAM areas.
`timescale 1ns/1ns
`default_nettype none
module fatu_detect
  import fatu_pkg::*;
(
  input wire fatu_fetch_t fetch,
  output fatu_hit_t hit
);
  // Offsets from the range base give one unsigned compare per range, which
  // also holds when a range starts at address zero.
  always_comb
  begin
    hit.in_sfr = fetch.valid &&
      ((fetch.addr - SFR_LO) <= (SFR_HI - SFR_LO)); // RQ14
    hit.in_ram = fetch.valid &&
      ((fetch.addr - RAM_LO) <= (RAM_HI - RAM_LO)); // RQ14
  end
endmodule
`default_nettype wire

// ==== bench/fatu_chk_sva.sv ====
// Checker for the trap requests and the internal reset.
`timescale 1ns/1ns
`default_nettype none
module fatu_chk
  import fatu_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire fatu_fetch_t fetch,
  input wire logic trap_action_select,
  input wire logic trap_interrupt_request,
  input wire logic trap_reset_request,
  input wire logic internal_resetn,
  input wire logic high_freq_osc_restart
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  int low_cnt;
  // Counts the cycles in which the trap reset holds the controller.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_cnt <= 0;
    end
    else if (!internal_resetn)
    begin
      low_cnt <= low_cnt + 1;
    end
    else
    begin
      low_cnt <= 0;
    end
  end
  sequence rst_begin;
    trap_reset_request && !internal_resetn;
  endsequence
  sequence sfr_take;
    fetch.valid && fetch.addr <= SFR_HI && internal_resetn;
  endsequence
  sfr_int_a: assert property (sfr_take ##0 !trap_action_select
    |=> trap_interrupt_request) else $error("no trap interrupt");
  sfr_rst_a: assert property (sfr_take ##0 trap_action_select
    |=> trap_reset_request) else $error("no trap reset");
  one_kind_a: assert property (!(trap_interrupt_request
    && trap_reset_request)) else $error("both requests high");
  far_fetch_a: assert property (fetch.valid && fetch.addr > RAM_HI
    |=> !trap_interrupt_request) else $error("trap on plain fetch");
  rst_pulse_a: assert property (trap_reset_request
    |=> !trap_reset_request) else $error("reset request too long");
  rst_len_a: assert property ($fell(internal_resetn)
    |-> ##[1:30] internal_resetn) else $error("trap reset too long");
  in_rst_a: assert property (trap_reset_request
    |-> !internal_resetn) else $error("reset request without reset");
  osc_a: assert property (high_freq_osc_restart
    |-> !internal_resetn) else $error("restart outside reset");
  rst_full_a: assert property ($rose(internal_resetn)
    |-> low_cnt == RST_CYC) else $error("trap reset length wrong");
  rst_hold_a: assert property (rst_begin
    |=> (!internal_resetn) [*8]) else $error("trap reset too short");
endmodule
bind fatu_top fatu_chk i_fatu_chk (.mclk(mclk), .resetn(resetn),
  .fetch(fetch), .trap_action_select(trap_action_select),
  .trap_interrupt_request(trap_interrupt_request),
  .trap_reset_request(trap_reset_request),
  .internal_resetn(internal_resetn),
  .high_freq_osc_restart(high_freq_osc_restart));
`default_nettype wire

// ==== bench/fatu_cpu_model.sv ====
// CPU side model that counts accepted trap interrupts.
`timescale 1ns/1ns
`default_nettype none
module fatu_cpu_model (
  input wire logic mclk,
  input wire logic trap_interrupt_request,
  output var int taken,
  output var int depth
);
  // Every trap is taken at once, whatever the master flag, even nested.
  // The handler runs with the stack already set up and leaves by the
  // non-maskable return one cycle later, so nesting piles up only on back-to-back requests.
  always @(posedge mclk)
  begin
    taken <= taken + int'(trap_interrupt_request);
    if (trap_interrupt_request)
      depth <= depth + 1;
    else if (depth > 0)
      depth <= depth - 1;
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Bench for the fetch address trap unit.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fatu_pkg::*;
  logic mclk = 0, resetn = 0, sel = 0, ren = 1, acw = 0, slow = 0;
  logic irq, rreq, irstn, osc;
  fatu_fetch_t fetch = '0;
  int taken, depth;
  int errors = 0, compares = 0;
  fatu_top i_fatu_top (.mclk(mclk), .resetn(resetn), .fetch(fetch),
    .trap_action_select(sel), .ram_trap_enable(ren),
    .assign_code_write(acw), .low_speed_mode_one(slow),
    .trap_interrupt_request(irq), .trap_reset_request(rreq),
    .internal_resetn(irstn), .high_freq_osc_restart(osc));
  fatu_cpu_model i_fatu_cpu_model (.mclk(mclk),
    .trap_interrupt_request(irq), .taken(taken), .depth(depth));
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic s, input logic e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask
  task automatic fet(input logic [15:0] a, input logic i, r);
    @(posedge mclk) fetch <= '{1'b1, a};
    @(posedge mclk) fetch.valid <= 1'b0;
    #1 chk(irq, i);
    chk(rreq, r);
  endtask
  task automatic arm(input logic v, w);
    @(posedge mclk) ren <= v;
    acw <= w;
    @(posedge mclk) acw <= 1'b0;
  endtask
  task automatic t_int();
    fet(16'h003f, 1, 0);
    fet(16'h0040, 1, 0);
    fet(16'h013f, 1, 0);
    fet(16'h0140, 0, 0);
    chk(taken == 3, 1);
    chk(depth == 0, 1);
  endtask
  task automatic t_arm();
    arm(0, 0);
    fet(16'h0100, 1, 0);
    arm(0, 1);
    fet(16'h0100, 0, 0);
    fet(16'h0010, 1, 0);
    arm(1, 1);
    fet(16'h0100, 1, 0);
  endtask
  task automatic t_rst(input logic s);
    arm(0, 1);
    @(posedge mclk) sel <= 1'b1;
    slow <= s;
    fet(16'h0020, 0, 1);
    chk(irstn, 0);
    chk(osc, s);
    fet(16'h0010, 0, 0);
    repeat (27) @(posedge mclk);
    #1 chk(irstn, 0);
    chk(osc, s);
    @(posedge mclk) sel <= 1'b0;
    #1 chk(irstn, 1);
    chk(osc, 0);
    fet(16'h0100, 1, 0);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge mclk);
    errors++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_int();
    t_arm();
    t_rst(1'b0);
    t_rst(1'b1);
    results();
  end
endmodule
`default_nettype wire
